//--- rtl/undervolt_pkg.sv
// Constants shared by the low-voltage detector control block
package undervolt_pkg;
    // Control register bit positions
    localparam int CTRL_FLAG_BIT   = 0;
    localparam int CTRL_ACTION_BIT = 1;
    localparam int CTRL_SOURCE_BIT = 2;
    localparam int CTRL_ON_BIT     = 7;
    localparam logic [7:0] CTRL_RESET_VALUE  = 8'h00;
    localparam logic [7:0] CTRL_WRITABLE     = 8'h86;
    localparam logic [3:0] LEVEL_RESET_VALUE = 4'h0;
    localparam logic       MASK_RESET_VALUE  = 1'b1;
    // Position of the detector pending bit in its flag register
    localparam int PENDING_BIT = 0;
    // Position of the cause bit in the reset cause register
    localparam int CAUSE_BIT   = 0;
endpackage : undervolt_pkg

//--- rtl/low_voltage_detector_ctrl.sv
// Control logic of the low-voltage detector: flag, reset and interrupt generation
// How it works
// R1 - Software masks, selects pin source, enables, waits 10 us, checks flag, picks reset.
// R2 - Selecting reset action while voltage is above threshold raises no reset.
// R3 - Software masks the interrupt before enabling the detector.
// R4 - Reset mode stop: write 00H, or clear action then enable.
// R5 - Interrupt mode stop: write 00H, or clear enable alone.
// R6 - Any reset sets the interrupt mask to one.
// R7 - Disabling in interrupt mode while below threshold raises the interrupt and sets pending.
// R8 - Bit 0 of the control register shows the current comparison result.
// R9 - Supply interrupt start: mask, select supply, level, enable, wait, clear pending, unmask.
// R10 - Pin interrupt start: mask, select pin, enable, wait, clear pending, unmask.
// R11 - Action and source select reset to zero.
// R12 - Interrupt service checks the flag then clears the pending bit.
// R13 - Near-threshold reset mode: software waits out fluctuation after reset release.
// R14 - A detector-caused reset is recorded in the reset cause bit.
// R15 - Reset mode asserts internal reset while below threshold, releases at or above.
// R16 - Interrupt mode raises the interrupt on falling below and on returning above.
// R17 - The comparator output is synchronised before any use.
`timescale 1ns/1ps
`default_nettype none
module low_voltage_detector_ctrl
    import undervolt_pkg::*;
(
    input  wire logic       i_core_clk,
    input  wire logic       i_reset_n,
    input  wire logic       i_ctrl_wr,
    input  wire logic [7:0] i_ctrl_wdata,
    input  wire logic       i_level_wr,
    input  wire logic [3:0] i_level_wdata,
    input  wire logic       i_mask_wr,
    input  wire logic       i_mask_wdata,
    input  wire logic       i_pending_clr,
    input  wire logic       i_cause_clr,
    input  wire logic       i_cmp_below,
    output logic [7:0]      o_detector_ctrl_reg,
    output logic [3:0]      o_level_select_reg,
    output logic            o_source_select,
    output logic            o_detector_irq_mask,
    output logic            o_detector_irq_pending,
    output logic            o_undervolt_irq,
    output logic            o_undervolt_reset,
    output logic            o_undervolt_reset_cause
);
    import undervolt_pkg::*;

    typedef struct packed {
        logic [2:0] sync;
        logic       below;
        logic       on;
        logic       action;
        logic       source;
        logic [3:0] level;
        logic       mask;
        logic       pending;
        logic       irq;
        logic       rst;
        logic       cause;
    } state_s;

    state_s state_reg;
    state_s state_next;

    logic       agree;
    logic       below_live;
    logic       on_w;
    logic       action_w;
    logic [7:0] wd;

    // The first stage is read only by the second stage
    assign agree      = state_reg.sync[1] == state_reg.sync[2];               // R17
    assign below_live = state_reg.below & state_reg.on;
    assign wd         = i_ctrl_wdata & CTRL_WRITABLE;
    assign on_w       = i_ctrl_wr ? wd[CTRL_ON_BIT] : state_reg.on;
    assign action_w   = i_ctrl_wr ? wd[CTRL_ACTION_BIT] : state_reg.action;

    always_comb begin
        state_next         = state_reg;
        state_next.sync    = {state_reg.sync[1:0], i_cmp_below};               // R17
        state_next.irq     = 1'b0;
        if (agree) begin
            state_next.below = state_reg.sync[2];                              // R17
        end
        if (i_ctrl_wr) begin
            state_next.on     = wd[CTRL_ON_BIT];
            state_next.action = wd[CTRL_ACTION_BIT];
            state_next.source = wd[CTRL_SOURCE_BIT];
        end
        if (i_level_wr) begin
            state_next.level = i_level_wdata;
        end
        if (i_mask_wr) begin
            state_next.mask = i_mask_wdata;
        end
        // Both level changes interrupt in interrupt mode
        if (state_reg.on && !state_reg.action && agree
                && (state_reg.sync[2] != state_reg.below)) begin
            state_next.irq = 1'b1;                                             // R16
        end
        // Turning off while below still reports, since software leaves the low state unseen
        if (state_reg.on && !on_w && below_live && !state_reg.action) begin
            state_next.irq = 1'b1;                                             // R7
        end
        // Reset follows the level only; no reset if above when action is chosen
        state_next.rst = on_w && action_w && state_reg.below;                  // R2 R15
        if (i_pending_clr) begin
            state_next.pending = 1'b0;
        end
        if (state_next.irq) begin
            state_next.pending = 1'b1;                                         // R7
        end
        if (i_cause_clr) begin
            state_next.cause = 1'b0;
        end
        if (state_reg.rst) begin
            state_next.cause = 1'b1;                                           // R14
            state_next.mask  = MASK_RESET_VALUE;                               // R6
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_reg         <= '0;
            state_reg.mask    <= MASK_RESET_VALUE;                             // R6
            state_reg.action  <= CTRL_RESET_VALUE[CTRL_ACTION_BIT];            // R11
            state_reg.source  <= CTRL_RESET_VALUE[CTRL_SOURCE_BIT];            // R11
            state_reg.level   <= LEVEL_RESET_VALUE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_comb begin
        o_detector_ctrl_reg                  = CTRL_RESET_VALUE;
        o_detector_ctrl_reg[CTRL_ON_BIT]     = state_reg.on;
        o_detector_ctrl_reg[CTRL_SOURCE_BIT] = state_reg.source;
        o_detector_ctrl_reg[CTRL_ACTION_BIT] = state_reg.action;
        o_detector_ctrl_reg[CTRL_FLAG_BIT]   = below_live;                     // R8
    end

    assign o_level_select_reg      = state_reg.level;
    assign o_source_select         = state_reg.source;
    assign o_detector_irq_mask     = state_reg.mask;
    assign o_detector_irq_pending  = state_reg.pending;
    assign o_undervolt_irq         = state_reg.irq;
    assign o_undervolt_reset       = state_reg.rst;                            // R15
    assign o_undervolt_reset_cause = state_reg.cause;                          // R14

    property p_reset_needs_low;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        o_undervolt_reset |-> $past(state_reg.below);
    endproperty
    a_reset_needs_low: assert property (p_reset_needs_low)                     // R2
        else $error("reset raised while voltage was above threshold");

    property p_reset_follows_low;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        (state_reg.on && state_reg.action && state_reg.below && !i_ctrl_wr)
            |=> o_undervolt_reset;
    endproperty
    a_reset_follows_low: assert property (p_reset_follows_low)                 // R15
        else $error("reset missing while below threshold in reset mode");

    property p_mask_after_reset;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        o_undervolt_reset |=> o_detector_irq_mask && o_undervolt_reset_cause;
    endproperty
    a_mask_after_reset: assert property (p_mask_after_reset)                   // R6
        else $error("mask or cause not set after detector reset");

    sequence s_off_while_low;
        state_reg.on && below_live && !state_reg.action && i_ctrl_wr
            && !wd[CTRL_ON_BIT];
    endsequence
    property p_off_low_irq;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        s_off_while_low |=> o_undervolt_irq && o_detector_irq_pending;
    endproperty
    a_off_low_irq: assert property (p_off_low_irq)                             // R7
        else $error("no interrupt when detector turned off below threshold");

    property p_flag_bit;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        (state_reg.on && agree && !i_ctrl_wr)
            |=> o_detector_ctrl_reg[CTRL_FLAG_BIT] == $past(state_reg.sync[2]);
    endproperty
    a_flag_bit: assert property (p_flag_bit)                                   // R8
        else $error("flag bit does not show comparison result");

    property p_edge_irq;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        ($changed(state_reg.below) && $past(state_reg.on) && !$past(state_reg.action))
            |-> o_undervolt_irq;
    endproperty
    a_edge_irq: assert property (p_edge_irq)                                   // R16
        else $error("level change gave no interrupt");

    property p_sync_three;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        $rose(state_reg.below) |-> $past(state_reg.sync[2]) && $past(state_reg.sync[1]);
    endproperty
    a_sync_three: assert property (p_sync_three)                               // R17
        else $error("flag changed before synchroniser stages agreed");

    property p_irq_pulse;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        o_undervolt_irq |-> o_detector_irq_pending;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse)                                 // R7
        else $error("pending not set with interrupt");

    // Pending stays until software clears it
    property p_pending_sticky;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        (o_detector_irq_pending && !i_pending_clr) |=> o_detector_irq_pending;
    endproperty
    a_pending_sticky: assert property (p_pending_sticky)                       // R7
        else $error("pending dropped without a clear");

    // The cause bit survives until software clears it
    property p_cause_sticky;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        (o_undervolt_reset_cause && !i_cause_clr) |=> o_undervolt_reset_cause;
    endproperty
    a_cause_sticky: assert property (p_cause_sticky)                           // R14
        else $error("reset cause dropped without a clear");

    property p_reset_values;
        @(posedge i_core_clk)
        $rose(i_reset_n) |-> !o_source_select && !o_detector_ctrl_reg[CTRL_ACTION_BIT];
    endproperty
    a_reset_values: assert property (p_reset_values)                           // R11
        else $error("select bits not zero after reset");
endmodule : low_voltage_detector_ctrl
`default_nettype wire

//--- verification/undervolt_cmp_model.sv
// Behavioural stand-in for the analog comparator feeding the detector
`timescale 1ns/1ps
`default_nettype none
module undervolt_cmp_model (
    input  wire logic i_below_req,
    output logic      o_cmp_below
);
    initial o_cmp_below = 1'b0;
    // Settles a few ns off the clock grid, so the sampling is truly asynchronous
    always @(i_below_req) o_cmp_below <= #7 i_below_req;
endmodule : undervolt_cmp_model
`default_nettype wire

//--- verification/tb_low_voltage_detector_ctrl.sv
// Self-checking testbench of the low-voltage detector control block
`timescale 1ns/1ps
`default_nettype none
module tb_low_voltage_detector_ctrl;
    import undervolt_pkg::*;
    logic       i_core_clk = 0, i_reset_n = 0, below_req = 0, cmp_below;
    logic       ctrl_wr = 0, level_wr = 0, mask_wr = 0, mask_wdata = 0;
    logic       pend_clr = 0, cause_clr = 0;
    logic [7:0] ctrl_wdata = 8'h00;
    logic [3:0] level_wdata = 4'h0, level;
    logic [7:0] ctrl;
    logic       src, mask, pend, irq, rst, cause;
    int         n_mismatch = 0, n_tests = 0, n_irq, n_rst;

    low_voltage_detector_ctrl DUT (
        .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_ctrl_wr(ctrl_wr),
        .i_ctrl_wdata(ctrl_wdata), .i_level_wr(level_wr), .i_level_wdata(level_wdata),
        .i_mask_wr(mask_wr), .i_mask_wdata(mask_wdata), .i_pending_clr(pend_clr),
        .i_cause_clr(cause_clr), .i_cmp_below(cmp_below), .o_detector_ctrl_reg(ctrl),
        .o_level_select_reg(level), .o_source_select(src), .o_detector_irq_mask(mask),
        .o_detector_irq_pending(pend), .o_undervolt_irq(irq), .o_undervolt_reset(rst),
        .o_undervolt_reset_cause(cause));
    undervolt_cmp_model cmp (.i_below_req(below_req), .o_cmp_below(cmp_below));

    initial begin
        forever #12.5 i_core_clk = ~i_core_clk;
    end

    task conclude;
        $display("Comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude

    task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task wr_ctrl(input logic [7:0] d);
        @(negedge i_core_clk);
        ctrl_wr = 1'b1;
        ctrl_wdata = d;
        @(negedge i_core_clk);
        ctrl_wr = 1'b0;
    endtask : wr_ctrl

    // k: 0 level write, 1 mask write, 2 pending clear, 3 cause clear
    task strobe(input int k, input logic [3:0] d);
        @(negedge i_core_clk);
        {cause_clr, pend_clr, mask_wr, level_wr} = 4'h1 << k;
        level_wdata = d;
        mask_wdata = d[0];
        @(negedge i_core_clk);
        {cause_clr, pend_clr, mask_wr, level_wr} = 4'h0;
    endtask : strobe

    // Moves the comparator, then counts interrupt pulses and reset cycles
    task settle(input logic below, input int n);
        below_req = below;
        n_irq = 0;
        n_rst = 0;
        repeat (n) begin
            @(negedge i_core_clk);
            n_irq += int'(irq === 1'b1);
            n_rst += int'(rst === 1'b1);
        end
    endtask : settle

    initial begin
        repeat (6) @(negedge i_core_clk);
        i_reset_n = 1'b1;
        chk("ctrl", CTRL_RESET_VALUE, ctrl);
        chk("mask", {7'h0, MASK_RESET_VALUE}, {7'h0, mask});
        chk("rst cause pend src", 8'h00, {4'h0, rst, cause, pend, src});
        strobe(0, 4'ha);
        chk("level", 8'h0a, {4'h0, level});
        wr_ctrl(8'hff);
        chk("ctrl", 8'h86, ctrl);
        chk("rst on above", 8'h00, {7'h0, rst});
        chk("src", 8'h01, {7'h0, src});
        wr_ctrl(8'h80);
        settle(1'b1, 10);
        chk("irq fall", 8'h01, 8'(n_irq));
        chk("flag below", 8'h81, ctrl);
        chk("pend", 8'h01, {7'h0, pend});
        strobe(2, 4'h0);
        chk("pend clr", 8'h00, {7'h0, pend});
        settle(1'b0, 10);
        chk("irq rise", 8'h01, 8'(n_irq));
        chk("flag above", 8'h80, ctrl);
        strobe(2, 4'h0);
        settle(1'b1, 10);
        strobe(2, 4'h0);
        wr_ctrl(8'h00);
        settle(1'b1, 4);
        chk("pend off below", 8'h01, {7'h0, pend});
        chk("flag off", 8'h00, ctrl);
        strobe(2, 4'h0);
        settle(1'b0, 10);
        strobe(1, 4'h1);
        wr_ctrl(8'h84);
        settle(1'b0, 10);
        chk("flag pin above", 8'h84, ctrl);
        settle(1'b1, 10);
        chk("pin irq fall", 8'h01, 8'(n_irq));
        chk("flag pin below", 8'h85, ctrl);
        strobe(2, 4'h0);
        settle(1'b0, 10);
        chk("pin irq rise", 8'h01, 8'(n_irq));
        strobe(2, 4'h0);
        wr_ctrl(8'h86);
        settle(1'b0, 10);
        chk("no reset above", 8'h00, 8'(n_rst));
        strobe(1, 4'h0);
        settle(1'b1, 10);
        chk("reset below", 8'h01, {7'h0, rst});
        chk("cause", 8'h01, {7'h0, cause});
        chk("mask by detector reset", 8'h01, {7'h0, mask});
        chk("irq in reset mode", 8'h00, 8'(n_irq));
        settle(1'b0, 10);
        chk("reset release", 8'h00, {7'h0, rst});
        wr_ctrl(8'h00);
        strobe(3, 4'h0);
        chk("cause clr", 8'h00, {7'h0, cause});
        strobe(1, 4'h0);
        chk("unmask", 8'h00, {7'h0, mask});
        wr_ctrl(8'h86);
        @(negedge i_core_clk);
        i_reset_n = 1'b0;
        #3;
        chk("mask mid reset", 8'h01, {7'h0, mask});
        chk("ctrl mid reset", 8'h00, ctrl);
        chk("level mid reset", 8'h00, {4'h0, level});
        @(negedge i_core_clk);
        i_reset_n = 1'b1;
        // Let the edges after release pass so the reset checks see them
        repeat (2) @(negedge i_core_clk);
        chk("ctrl after reset", 8'h00, ctrl);
        chk("mask after reset", 8'h01, {7'h0, mask});
        conclude();
    end

    // About twenty times the planned run length
    initial begin
        #75000;
        n_mismatch++;
        conclude();
    end
endmodule : tb_low_voltage_detector_ctrl
`default_nettype wire
